// *** shared/cfg_header_pkg.sv ***
/*
  Constants and carrier types for the configuration header slice of the
  serial bus host controller function. Assumes the configuration access
  port of the top module presents byte addresses with dword alignment.
*/
package cfg_header_pkg;

  localparam logic [7:0]  CLASS_OFFSET     = 8'h08;
  localparam logic [7:0]  TENURE_OFFSET    = 8'h0c;
  localparam logic [7:0]  WINDOW_OFFSET    = 8'h10;

  localparam logic [7:0]  CATEGORY_VALUE   = 8'h0c;
  localparam logic [7:0]  SUBCLASS_VALUE   = 8'h00;
  localparam logic [7:0]  PROG_MODEL_VALUE = 8'h10;
  localparam logic [7:0]  SELF_CHECK_VALUE = 8'h00;
  localparam logic [7:0]  LAYOUT_VALUE     = 8'h00;
  localparam logic [6:0]  WINDOW_SIZE_VAL  = 7'h00;
  localparam logic        PREFETCH_VAL     = 1'b0;
  localparam logic [1:0]  DECODE_KIND_VAL  = 2'h0;
  localparam logic        SPACE_IND_VAL    = 1'b0;
  localparam logic [1:0]  DEVSEL_TIMING    = 2'h1;

  localparam logic [7:0]  TENURE_RESET     = 8'h00;
  localparam logic [7:0]  LINE_RESET       = 8'h00;
  localparam logic [20:0] BASE_PTR_RESET   = 21'h000000;
  localparam int          BASE_PTR_LSB     = 11;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_s;

endpackage : cfg_header_pkg

// *** design/cfg_header_regs.sv ***
/*
  Configuration header registers and bus tenure limit timer of the serial
  bus host controller function. Assumes the configuration access port and
  the initiator frame signal come from logic on clk_i, while the grant pin
  arrives from the bus asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - The class register top byte is fixed to the serial bus controller category.
// - The class register second byte is fixed to the serial bus subclass.
// - The class register third byte is fixed to the host controller programming model.
// - The class register low byte returns a fixed silicon version code.
// - The writable tenure limit byte resets to zero and counts clocks from initiator frame start.
// - After the tenure limit expires the running transaction ends once the grant is withdrawn.
// - The writable line length byte resets to zero and is handed to the burst transfer logic.
// - The self check byte is read-only and returns zero.
// - The layout byte is read-only zero, so its bit 7 marks a single-function device.
// - Writing all ones to the window base reads back as a 2K-byte window request.
// - Window base bits 31 to 11 are writable and reset to zero.
// - Window base bits 10 to 4 read as zero, giving a 2K-byte size.
// - Window base bit 3 reads zero, marking the window nonprefetchable.
// - Window base bits 2 to 1 read zero, marking a 32-bit decoder.
// - Window base bit 0 reads zero, marking memory space.
// - Device select timing is the fixed medium code.
module cfg_header_regs
  import cfg_header_pkg::*;
#(
  parameter logic [7:0] SILICON_VERSION = 8'h5a  // Arbitrary value.
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire cfg_req_s    cfg_i,
  output var  cfg_rsp_s    cfg_o,
  input  wire logic        frame_active_i,
  input  wire logic        gnt_n_i,
  output logic             end_transfer_o,
  output logic             tenure_expired_o,
  output logic [7:0]       line_length_setting_o,
  output logic [31:0]      window_base_pointer_o,
  output logic [1:0]       devsel_timing_o
);

  // The block keeps three kinds of state. The stored configuration bytes
  // are the tenure limit, the line length setting and the window base;
  // only host writes change them. The tenure timer counts clocks while
  // the controller is initiator and raises the stop request once the
  // limit is used up and the grant has been taken away. The access port
  // answers every request, mapped or not, with a one-clock acknowledge.
  // Nothing here depends on the order of accesses, so the host may issue
  // a request on every clock.

  // Limitation: the stop request reaches the frame logic three clocks
  // after the grant pin moves, two for the synchroniser and one for the
  // output register, so the bus arbiter must tolerate that latency.

  // Limitation: the tenure counter is eight bits wide and stops once the
  // limit is met, so it cannot wrap and report a second expiry in one
  // frame. A new frame start is the only thing that clears the expiry.
  // The trade is a slightly wider compare against a simpler reload path.

  // Every register of the block lives in this one struct, so the reset
  // value and the next-state copy cannot drift apart field by field.
  typedef struct packed {
    logic [7:0]  tenure;
    logic [7:0]  line;
    logic [20:0] base_ptr;
    logic [7:0]  count;
    logic        expired;
    logic        frame_prev;
    logic [1:0]  gnt_sync;
    logic        stop;
    logic        ack;
    logic [31:0] rdata;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  // Byte lane merge for writes that carry byte enables. A lane without
  // its enable keeps the old byte, so partial writes never disturb the
  // neighbouring field.
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    merge_byte = en ? new_v : old_v;
  endfunction : merge_byte

  // Dword match. The two low address bits never select a register, so a
  // byte address anywhere inside the dword hits the same word.
  function automatic logic word_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    word_hit = (addr[7:2] == offset[7:2]);
  endfunction : word_hit

  // Read word select. Unmapped dwords read as zero so a probing host
  // sees an empty slot rather than a stale value.
  function automatic logic [31:0] read_select(input logic        h_class,
                                              input logic        h_tenure,
                                              input logic        h_window,
                                              input logic [31:0] class_w,
                                              input logic [31:0] tenure_w,
                                              input logic [31:0] window_w);
    read_select = 32'h00000000;
    if (h_class) begin
      read_select = class_w;
    end
    if (h_tenure) begin
      read_select = tenure_w;
    end
    if (h_window) begin
      read_select = window_w;
    end
  endfunction : read_select

  // Named fields of the three words.
  logic [7:0]  function_category_byte;
  logic [7:0]  subclass_byte;
  logic [7:0]  programming_model_byte;
  logic [7:0]  silicon_version_byte;
  logic [7:0]  self_check_field;
  logic [7:0]  layout_byte;
  logic [20:0] window_base_pointer;
  logic [6:0]  window_size_field;
  logic        prefetch_flag;
  logic [1:0]  decode_width_kind;
  logic        space_indicator;

  // Assembled words and the write merge.
  logic [31:0] class_word;
  logic [31:0] tenure_word;
  logic [31:0] window_word;
  logic [31:0] base_merged;

  // Access decode.
  logic        rd_req;
  logic        wr_req;
  logic        hit_class;
  logic        hit_tenure;
  logic        hit_window;
  logic [31:0] rd_word;

  // Next values of the stored bytes and of the timer terms.
  logic [7:0]  nxt_line;
  logic [7:0]  nxt_tenure;
  logic [20:0] nxt_base_ptr;
  logic        frame_start;
  logic        frame_running;
  logic [7:0]  count_inc;
  logic        limit_met;
  logic        limit_zero;
  logic        grant_gone;
  logic        nxt_stop;

  // Fixed fields are wired from constants and have no storage, so there
  // is nothing that a write to them could disturb.
  always_comb begin
    function_category_byte = CATEGORY_VALUE;
    subclass_byte          = SUBCLASS_VALUE;
    programming_model_byte = PROG_MODEL_VALUE;
    silicon_version_byte   = SILICON_VERSION;
    self_check_field       = SELF_CHECK_VALUE;
    layout_byte            = LAYOUT_VALUE;
    window_base_pointer    = state_ff.base_ptr;
    window_size_field      = WINDOW_SIZE_VAL;
    prefetch_flag          = PREFETCH_VAL;
    decode_width_kind      = DECODE_KIND_VAL;
    space_indicator        = SPACE_IND_VAL;
  end

  // Word assembly. The stored bytes of the tenure word sit in its two
  // low lanes, next to the fixed layout and self check bytes.
  always_comb begin
    class_word  = {function_category_byte, subclass_byte,
                   programming_model_byte, silicon_version_byte};
    tenure_word = {self_check_field, layout_byte, state_ff.tenure, state_ff.line};
    // Low bits are constants, so an all-ones write reads back as the size mask.
    window_word = {window_base_pointer, window_size_field, prefetch_flag,
                   decode_width_kind, space_indicator};
  end

  // Access decode, shared by the read path and the write path so the two
  // can never disagree about which word an address selects.
  always_comb begin
    rd_req     = cfg_i.valid & ~cfg_i.write;
    wr_req     = cfg_i.valid & cfg_i.write;
    hit_class  = word_hit(cfg_i.addr, CLASS_OFFSET);
    hit_tenure = word_hit(cfg_i.addr, TENURE_OFFSET);
    hit_window = word_hit(cfg_i.addr, WINDOW_OFFSET);
    rd_word    = read_select(hit_class, hit_tenure, hit_window,
                             class_word, tenure_word, window_word);
  end

  // Write path. Only the writable bytes are stored; a write that names a
  // fixed byte finds nothing to change, and the window low byte is taken
  // from the constant word so it can never pick up write data.
  always_comb begin
    base_merged  = {merge_byte(window_word[31:24], cfg_i.wdata[31:24], cfg_i.byte_en[3]),
                    merge_byte(window_word[23:16], cfg_i.wdata[23:16], cfg_i.byte_en[2]),
                    merge_byte(window_word[15:8], cfg_i.wdata[15:8], cfg_i.byte_en[1]),
                    window_word[7:0]};
    nxt_line     = state_ff.line;
    nxt_tenure   = state_ff.tenure;
    nxt_base_ptr = state_ff.base_ptr;
    if (wr_req && hit_tenure) begin
      nxt_line   = merge_byte(state_ff.line, cfg_i.wdata[7:0],
                              cfg_i.byte_en[0]);
      nxt_tenure = merge_byte(state_ff.tenure, cfg_i.wdata[15:8],
                              cfg_i.byte_en[1]);
    end
    if (wr_req && hit_window) begin
      nxt_base_ptr = base_merged[31:BASE_PTR_LSB];
    end
  end

  // Tenure timer terms. A limit of zero counts as met at the frame start,
  // so a host that never programs the timer cannot hold the bus longer
  // than the arbiter allows.
  always_comb begin
    frame_start   = frame_active_i & ~state_ff.frame_prev;
    frame_running = frame_active_i & ~frame_start;
    // The compare stays within eight bits because the counter stops at the limit.
    count_inc     = state_ff.count + 8'h01;
    limit_met     = (count_inc >= state_ff.tenure);
    limit_zero    = (state_ff.tenure == 8'h00);
  end

  // Grant is sampled through two flops, so grant_gone lags the pin by two
  // cycles and the registered stop by three; only the second flop is read here.
  always_comb begin
    grant_gone = state_ff.gnt_sync[1];
    nxt_stop   = frame_running & state_ff.expired & grant_gone;
  end

  // One process fills the whole next-state copy from the terms above.
  always_comb begin
    nxt_state            = state_ff;

    // Synchroniser shift and frame edge history.
    nxt_state.gnt_sync   = {state_ff.gnt_sync[0], gnt_n_i};
    nxt_state.frame_prev = frame_active_i;

    // Every access is acknowledged one clock later, mapped or not.
    nxt_state.ack        = cfg_i.valid;

    // Stored bytes and the stop request.
    nxt_state.line       = nxt_line;
    nxt_state.tenure     = nxt_tenure;
    nxt_state.base_ptr   = nxt_base_ptr;
    nxt_state.stop       = nxt_stop;

    // Read data is captured with the acknowledge and held until the next read.
    if (rd_req) begin
      nxt_state.rdata = rd_word;
    end

    // Counter restarts at frame start and saturates once the limit is met.
    if (frame_start) begin
      nxt_state.count   = 8'h00;
      nxt_state.expired = limit_zero;
    end else if (frame_active_i && !state_ff.expired) begin
      nxt_state.count   = count_inc;
      nxt_state.expired = limit_met;
    end
  end

  // Reset loads constants only. The grant copies start deasserted, so
  // grant_gone reads as a withdrawn grant until the real pin level is shifted in.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff.tenure     <= TENURE_RESET;
      state_ff.line       <= LINE_RESET;
      state_ff.base_ptr   <= BASE_PTR_RESET;
      state_ff.count      <= 8'h00;
      state_ff.expired    <= 1'b0;
      state_ff.frame_prev <= 1'b0;
      state_ff.gnt_sync   <= 2'h3;
      state_ff.stop       <= 1'b0;
      state_ff.ack        <= 1'b0;
      state_ff.rdata      <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Data outputs come from flops, with window base bits 10 to 0 tied to constants; the timing code is a
  // constant because the device select speed cannot be changed.
  assign cfg_o.ack             = state_ff.ack;
  assign cfg_o.rdata           = state_ff.rdata;
  assign end_transfer_o        = state_ff.stop;
  assign tenure_expired_o      = state_ff.expired;
  assign line_length_setting_o = state_ff.line;
  assign window_base_pointer_o = window_word;
  assign devsel_timing_o       = DEVSEL_TIMING;

endmodule : cfg_header_regs

`default_nettype wire

// *** verification/bus_arbiter_model.sv ***
/*
  Bus arbiter model that grants the initiator and withdraws the grant on command.
  Assumes the bench changes withdraw_i only at a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_arbiter_model (
  input  wire logic clk_i,
  input  wire logic withdraw_i,
  output var  logic gnt_n_o
);
  initial gnt_n_o = 1'b1;
  // The grant pin is registered, so a withdrawal lags the command by one edge.
  always @(posedge clk_i) gnt_n_o <= withdraw_i;
endmodule : bus_arbiter_model
`default_nettype wire

// *** verification/cfg_header_regs_asserts.sv ***
/*
  Port assertions for the configuration header registers.
  Assumes one clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_header_regs_asserts
  import cfg_header_pkg::*;
#(parameter logic [7:0] SILICON_VERSION = 8'h5a) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire cfg_req_s    cfg_i,
  input wire cfg_rsp_s    cfg_o,
  input wire logic        frame_active_i,
  input wire logic        end_transfer_o,
  input wire logic [7:0]  line_length_setting_o,
  input wire logic [31:0] window_base_pointer_o,
  input wire logic [1:0]  devsel_timing_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_s(logic [7:0] a);
    cfg_i.valid && !cfg_i.write && cfg_i.addr[7:2] == a[7:2];
  endsequence
  sequence wr_s(logic [7:0] a, logic [3:0] m);
    cfg_i.valid && cfg_i.write && cfg_i.addr[7:2] == a[7:2] && (cfg_i.byte_en & m) == m;
  endsequence
  a_ack_follows_req: assert property (cfg_i.valid |=> cfg_o.ack) else $error("ack missing");
  a_no_stray_ack: assert property (!cfg_i.valid |=> !cfg_o.ack) else $error("stray ack");
  a_class_fixed: assert property (rd_s(CLASS_OFFSET) |=> cfg_o.rdata ==
    {CATEGORY_VALUE, SUBCLASS_VALUE, PROG_MODEL_VALUE, SILICON_VERSION}) else $error("class");
  a_layout_zero: assert property (rd_s(TENURE_OFFSET) |=> cfg_o.rdata[31:16] == 16'h0000)
    else $error("layout");
  a_window_low_zero: assert property (rd_s(WINDOW_OFFSET) |=> cfg_o.rdata[10:0] == 11'h000)
    else $error("window low bits");
  a_window_write: assert property (wr_s(WINDOW_OFFSET, 4'hf) |=> window_base_pointer_o ==
    {$past(cfg_i.wdata[31:11]), 11'h000}) else $error("window write");
  a_line_write: assert property (wr_s(TENURE_OFFSET, 4'h1) |=> line_length_setting_o ==
    $past(cfg_i.wdata[7:0])) else $error("line write");
  a_devsel_fixed: assert property (devsel_timing_o == DEVSEL_TIMING) else $error("devsel");
  a_end_in_frame: assert property (end_transfer_o |-> $past(frame_active_i)) else $error("end");
endmodule : cfg_header_regs_asserts
`default_nettype wire

// *** verification/cfg_header_regs_tb.sv ***
/*
  Self-checking bench for the configuration header registers.
  Assumes the package, the design, the arbiter model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_header_regs_tb;
  import cfg_header_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, frame_active_i = 1'b0, withdraw = 1'b0, gnt_n;
  logic end_transfer_o, tenure_expired_o;
  logic [7:0] line_o;
  logic [31:0] win_o;
  logic [1:0] devsel_o;
  cfg_req_s cfg_i = '0;
  cfg_rsp_s cfg_o;
  int err_total = 0, samples_checked = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  cfg_header_regs #(.SILICON_VERSION(8'h5a)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_i(cfg_i), .cfg_o(cfg_o), .frame_active_i(frame_active_i), .gnt_n_i(gnt_n),
    .end_transfer_o(end_transfer_o), .tenure_expired_o(tenure_expired_o),
    .line_length_setting_o(line_o), .window_base_pointer_o(win_o), .devsel_timing_o(devsel_o));
  bus_arbiter_model arb_u (.clk_i(clk_i), .withdraw_i(withdraw), .gnt_n_o(gnt_n));
  task conclude;
    $display("checked %0d, wrong %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One access per call; the next call may start at the following edge.
  task acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
           input logic [31:0] exp);
    @(posedge clk_i) cfg_i <= '{1'b1, w, a, be, d};
    @(posedge clk_i) cfg_i.valid <= 1'b0;
    #1 chk({31'h0, cfg_o.ack}, 32'h1);
    if (!w) chk(cfg_o.rdata, exp);
  endtask : acc
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, 8'h08, 4'h0, 32'h0, 32'h0c00105a);
    acc(1'b0, 8'h0c, 4'h0, 32'h0, 32'h0);
    acc(1'b0, 8'h10, 4'h0, 32'h0, 32'h0);
    acc(1'b1, 8'h08, 4'hf, '1, 32'h0);
    acc(1'b0, 8'h08, 4'h0, 32'h0, 32'h0c00105a);
    acc(1'b1, 8'h0c, 4'hf, '1, 32'h0);
    acc(1'b0, 8'h0c, 4'h0, 32'h0, 32'h0000ffff);
    acc(1'b1, 8'h10, 4'hf, '1, 32'h0);
    acc(1'b0, 8'h10, 4'h0, 32'h0, 32'hfffff800);
    chk(win_o, 32'hfffff800);
    chk({30'h0, devsel_o}, 32'h1);
    $display("register test done");
    acc(1'b1, 8'h0c, 4'h2, 32'h00000200, 32'h0);
    chk({24'h0, line_o}, 32'hff);
    @(posedge clk_i) frame_active_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, tenure_expired_o}, 32'h0);
    @(posedge clk_i);
    #1 chk({31'h0, tenure_expired_o}, 32'h1);
    repeat (3) @(posedge clk_i);
    #1 chk({31'h0, end_transfer_o}, 32'h0);
    @(posedge clk_i) withdraw <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk({31'h0, end_transfer_o}, 32'h1);
    @(posedge clk_i) frame_active_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({31'h0, end_transfer_o}, 32'h0);
    $display("tenure test done");
    conclude();
  end
endmodule : cfg_header_regs_tb
bind cfg_header_regs cfg_header_regs_asserts #(.SILICON_VERSION(SILICON_VERSION)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .cfg_o(cfg_o),
  .frame_active_i(frame_active_i), .end_transfer_o(end_transfer_o),
  .line_length_setting_o(line_length_setting_o),
  .window_base_pointer_o(window_base_pointer_o), .devsel_timing_o(devsel_timing_o));
`default_nettype wire
